/* File: src/lcd_display_ctrl.sv */
`timescale 1ns/1ps

module lcd_display_ctrl #(
    parameter int unsigned MUX_PERIOD_CYC = lcd_pkg::MUX_PERIOD_CYC,
    parameter int unsigned BANK_ON_CYC    = lcd_pkg::BANK_ON_CYC,
    parameter int unsigned BLINK_HALF_CYC = lcd_pkg::BLINK_HALF_CYC,
    parameter int unsigned DISPLAY_REQUEST_N_LONG_CYC  = lcd_pkg::DISPLAY_REQUEST_N_LONG_CYC,
    parameter int unsigned DISPLAY_REQUEST_N_SHORT_CYC = lcd_pkg::DISPLAY_REQUEST_N_SHORT_CYC
) (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_clk_en,
    // decoded register writes from the serial link
    input  wire logic        i_cmd_wr,
    input  wire logic [6:0]  i_cmd_addr,
    input  wire logic [7:0]  i_cmd_data,
    // gauge core
    input  wire logic [7:0]  i_programmed_full_count,
    input  wire logic        i_capacity_wr,
    input  wire logic [15:0] i_capacity_value,
    input  wire logic [7:0]  i_relative_charge,
    input  wire logic        i_first_low_voltage,
    input  wire logic        i_final_low_voltage,
    // pins
    input  wire logic        i_display_request_n,
    input  wire logic [1:0]  i_display_mode_strap,
    input  wire logic        i_full_init_strap,
    // led drive
    output logic      [4:0]  o_led_segment_oe,
    output logic             o_led_common_drive,
    // register readback
    output logic      [7:0]  o_full_capacity_reference,
    output logic      [7:0]  o_capacity_high_byte,
    output logic      [7:0]  o_capacity_low_byte,
    output logic      [7:0]  o_relative_charge,
    output logic      [7:0]  o_primary_flags
);

    lcd_pkg::lcd_state_t state_q;
    lcd_pkg::lcd_state_t state_d;
    lcd_pkg::lcd_mode_t  mode_q;
    lcd_pkg::lcd_mode_t  mode_d;
    logic [7:0]          fcr_q;
    logic [7:0]          fcr_d;
    logic [7:0]          capacity_high_byte_q;
    logic [7:0]          capacity_high_byte_d;
    logic [7:0]          capacity_low_byte_q;
    logic [7:0]          capacity_low_byte_d;
    logic [7:0]          rc_q;
    logic [7:0]          rc_d;
    logic [7:0]          flags_q;
    logic [7:0]          flags_d;

    logic                req_prev_q;
    logic                req_prev_d;
    logic [31:0]         display_request_n_cnt_q;
    logic [31:0]         display_request_n_cnt_d;
    logic [31:0]         mux_cnt_q;
    logic [31:0]         mux_cnt_d;
    logic [31:0]         blink_cnt_q;
    logic [31:0]         blink_cnt_d;
    logic                blink_q;
    logic                blink_d;

    logic [4:0]          seg_oe_q;
    logic [4:0]          seg_oe_d;
    logic                led_common_drive_q;
    logic                led_common_drive_d;

    logic [4:0]          pattern;
    logic                blink_led_segment_one;
    logic                reinit_cmd;
    logic                req_start;
    logic                bank_odd;
    logic                bank_even;
    logic                display_request_n_active;
    logic [4:0]          lit;

    lcd_band_decode u_band (
        .i_compensated_capacity    ({capacity_high_byte_q, capacity_low_byte_q}),
        .i_full_capacity_reference (fcr_q),
        .i_mode                    (mode_q),
        .i_first_low_voltage_flag  (flags_q[lcd_pkg::FLAG_FIRST_LOW_VOLTAGE_FLAG_BIT]),
        .o_pattern                 (pattern),
        .o_blink_led_segment_one              (blink_led_segment_one)
    );

    assign reinit_cmd = i_cmd_wr
        && (i_cmd_addr == lcd_pkg::CMD_WORD_ADDR)
        && (i_cmd_data == lcd_pkg::CMD_REINIT);

    // ---------------- register state ----------------
    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        fcr_d   = fcr_q;
        capacity_high_byte_d  = capacity_high_byte_q;
        capacity_low_byte_d  = capacity_low_byte_q;
        rc_d    = rc_q;
        flags_d = flags_q;
        case (state_q)
            lcd_pkg::LCD_ST_INIT: begin
                // straps sampled here, after reset release
                mode_d = lcd_pkg::lcd_mode_t'(i_display_mode_strap);
                if (i_full_init_strap) begin
                    fcr_d   = i_programmed_full_count;
                    capacity_high_byte_d  = i_programmed_full_count;
                    capacity_low_byte_d  = lcd_pkg::INIT_CAPL;
                    rc_d    = lcd_pkg::INIT_RC_FULL;
                    flags_d = lcd_pkg::INIT_FLAGS_FULL;
                end else begin
                    fcr_d   = lcd_pkg::RST_BYTE;
                    capacity_high_byte_d  = lcd_pkg::RST_BYTE;
                    capacity_low_byte_d  = lcd_pkg::RST_BYTE;
                    rc_d    = lcd_pkg::INIT_RC_EMPTY;
                    flags_d = lcd_pkg::INIT_FLAGS_EMPTY;
                end
                // a live low-voltage condition is not lost by the init
                flags_d[lcd_pkg::FLAG_FIRST_LOW_VOLTAGE_FLAG_BIT] = i_first_low_voltage;
                flags_d[lcd_pkg::FLAG_FINAL_LOW_VOLTAGE_FLAG_BIT] = i_final_low_voltage;
                state_d = lcd_pkg::LCD_ST_RUN;
            end
            lcd_pkg::LCD_ST_RUN: begin
                if (i_capacity_wr) begin
                    capacity_high_byte_d = i_capacity_value[15:8];
                    capacity_low_byte_d = i_capacity_value[7:0];
                    rc_d   = i_relative_charge;
                end
                flags_d[lcd_pkg::FLAG_FIRST_LOW_VOLTAGE_FLAG_BIT] = i_first_low_voltage;
                flags_d[lcd_pkg::FLAG_FINAL_LOW_VOLTAGE_FLAG_BIT] = i_final_low_voltage;
                if (reinit_cmd) begin
                    state_d = lcd_pkg::LCD_ST_INIT;
                end
            end
            default: begin
                state_d = lcd_pkg::LCD_ST_INIT;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q <= lcd_pkg::LCD_ST_INIT;
            mode_q  <= lcd_pkg::LCD_MODE_INC;
            fcr_q   <= lcd_pkg::RST_BYTE;
            capacity_high_byte_q  <= lcd_pkg::RST_BYTE;
            capacity_low_byte_q  <= lcd_pkg::RST_BYTE;
            rc_q    <= lcd_pkg::RST_BYTE;
            flags_q <= lcd_pkg::RST_BYTE;
        end else if (i_clk_en) begin
            state_q <= state_d;
            mode_q  <= mode_d;
            fcr_q   <= fcr_d;
            capacity_high_byte_q  <= capacity_high_byte_d;
            capacity_low_byte_q  <= capacity_low_byte_d;
            rc_q    <= rc_d;
            flags_q <= flags_d;
        end
    end

    // ---------------- timers ----------------
    assign req_start = req_prev_q && !i_display_request_n;

    always_comb begin
        req_prev_d  = i_display_request_n;
        display_request_n_cnt_d  = display_request_n_cnt_q;
        mux_cnt_d   = mux_cnt_q + 32'h00000001;
        blink_cnt_d = blink_cnt_q + 32'h00000001;
        blink_d     = blink_q;
        if (mux_cnt_q >= MUX_PERIOD_CYC - 32'h00000001) begin
            mux_cnt_d = 32'h00000000;
        end
        if (blink_cnt_q >= BLINK_HALF_CYC - 32'h00000001) begin
            blink_cnt_d = 32'h00000000;
            blink_d     = !blink_q;
        end
        if (state_q != lcd_pkg::LCD_ST_RUN) begin
            display_request_n_cnt_d = 32'h00000000;
        end else if (req_start) begin
            // falling edge of the request restarts the period
            if (mode_q == lcd_pkg::LCD_MODE_INC) begin
                display_request_n_cnt_d = DISPLAY_REQUEST_N_LONG_CYC;
            end else begin
                display_request_n_cnt_d = DISPLAY_REQUEST_N_SHORT_CYC;
            end
        end else if (display_request_n_cnt_q != 32'h00000000) begin
            display_request_n_cnt_d = display_request_n_cnt_q - 32'h00000001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            req_prev_q  <= 1'b1;
            display_request_n_cnt_q  <= 32'h00000000;
            mux_cnt_q   <= 32'h00000000;
            blink_cnt_q <= 32'h00000000;
            blink_q     <= 1'b0;
        end else if (i_clk_en) begin
            req_prev_q  <= req_prev_d;
            display_request_n_cnt_q  <= display_request_n_cnt_d;
            mux_cnt_q   <= mux_cnt_d;
            blink_cnt_q <= blink_cnt_d;
            blink_q     <= blink_d;
        end
    end

    // ---------------- segment drive ----------------
    // odd bank in the first 30%, even bank from mid-period for 30%
    assign bank_odd  = mux_cnt_q < BANK_ON_CYC;
    assign bank_even = (mux_cnt_q >= (MUX_PERIOD_CYC >> 1))
        && (mux_cnt_q < (MUX_PERIOD_CYC >> 1) + BANK_ON_CYC);

    assign display_request_n_active = (state_q == lcd_pkg::LCD_ST_RUN)
        && (display_request_n_cnt_q != 32'h00000000)
        && !i_display_request_n
        && !flags_q[lcd_pkg::FLAG_FINAL_LOW_VOLTAGE_FLAG_BIT];

    always_comb begin
        lit = pattern;
        if (blink_led_segment_one && !blink_q) begin
            lit[0] = 1'b0;
        end
        seg_oe_d = lcd_pkg::SEG_NONE;
        if (display_request_n_active) begin
            if (bank_odd) begin
                seg_oe_d = lit & lcd_pkg::BANK_ODD_MASK;
            end else if (bank_even) begin
                seg_oe_d = lit & lcd_pkg::BANK_EVEN_MASK;
            end
        end
        // common switch is registered from a RUN-only term: off in init after reset, but a reinit drops it one cycle late
        led_common_drive_d = display_request_n_active;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            seg_oe_q <= lcd_pkg::SEG_NONE;
            led_common_drive_q   <= 1'b0;
        end else if (i_clk_en) begin
            seg_oe_q <= seg_oe_d;
            led_common_drive_q   <= led_common_drive_d;
        end
    end

    assign o_led_segment_oe          = seg_oe_q;
    assign o_led_common_drive        = led_common_drive_q;
    assign o_full_capacity_reference = fcr_q;
    assign o_capacity_high_byte      = capacity_high_byte_q;
    assign o_capacity_low_byte       = capacity_low_byte_q;
    assign o_relative_charge         = rc_q;
    assign o_primary_flags           = flags_q;

endmodule // lcd_display_ctrl

/* File: pkg/lcd_pkg.sv */
package lcd_pkg;

    // command word register
    localparam logic [6:0] CMD_WORD_ADDR   = 7'h00;
    localparam logic [7:0] CMD_REINIT      = 8'h78;

    // primary flags field positions
    localparam int FLAG_INIT_BIT   = 7;
    localparam int FLAG_CPIN_BIT   = 4;
    localparam int FLAG_FIRST_LOW_VOLTAGE_FLAG_BIT   = 1;
    localparam int FLAG_FINAL_LOW_VOLTAGE_FLAG_BIT   = 0;

    // initialization values
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] INIT_RC_FULL    = 8'h64;
    localparam logic [7:0] INIT_RC_EMPTY   = 8'h00;
    localparam logic [7:0] INIT_FLAGS_FULL = 8'h90;
    localparam logic [7:0] INIT_FLAGS_EMPTY = 8'h10;
    localparam logic [7:0] INIT_CAPL       = 8'h00;

    // band thresholds in percent, ascending: 10 20 40 50 60 70 80 90
    localparam int         NUM_BANDS = 8;
    localparam logic [55:0] BAND_PCT = {7'h5A, 7'h50, 7'h46, 7'h3C,
                                        7'h32, 7'h28, 7'h14, 7'h0A};
    localparam int B10 = 0;
    localparam int B20 = 1;
    localparam int B40 = 2;
    localparam int B50 = 3;
    localparam int B60 = 4;
    localparam int B70 = 5;
    localparam int B80 = 6;
    localparam int B90 = 7;
    localparam logic [23:0] PCT_FULL = 24'h000064;

    // segment bank masks
    localparam logic [4:0] BANK_ODD_MASK  = 5'h15;
    localparam logic [4:0] BANK_EVEN_MASK = 5'h0A;
    localparam logic [4:0] SEG_NONE       = 5'h00;

    // timing
    localparam int unsigned CLK_FREQ_HZ   = 32'h05F5E100;
    localparam int unsigned MUX_RATE_HZ   = 32'h00000064;
    localparam int unsigned BANK_DUTY_PCT = 32'h0000001E;
    localparam int unsigned BLINK_RATE_HZ = 32'h00000004;
    localparam int unsigned DISPLAY_REQUEST_N_LONG_S   = 32'h0000000A;
    localparam int unsigned DISPLAY_REQUEST_N_SHORT_S  = 32'h00000004;
    localparam int unsigned MUX_PERIOD_CYC = CLK_FREQ_HZ / MUX_RATE_HZ;
    localparam int unsigned BANK_ON_CYC    =
        MUX_PERIOD_CYC * BANK_DUTY_PCT / 32'h00000064;
    localparam int unsigned BLINK_HALF_CYC =
        CLK_FREQ_HZ / (32'h00000002 * BLINK_RATE_HZ);
    localparam int unsigned DISPLAY_REQUEST_N_LONG_CYC  = DISPLAY_REQUEST_N_LONG_S * CLK_FREQ_HZ;
    localparam int unsigned DISPLAY_REQUEST_N_SHORT_CYC = DISPLAY_REQUEST_N_SHORT_S * CLK_FREQ_HZ;

    typedef enum logic [1:0] {
        LCD_ST_INIT = 2'h1,
        LCD_ST_RUN  = 2'h2
    } lcd_state_t;

    // strap coding: 00 low, 01 high, 10 floating
    typedef enum logic [1:0] {
        LCD_MODE_INC = 2'h0,
        LCD_MODE_BIN = 2'h1,
        LCD_MODE_BAR = 2'h2,
        LCD_MODE_RSV = 2'h3
    } lcd_mode_t;

endpackage

/* File: src/lcd_band_decode.sv */
`timescale 1ns/1ps

module lcd_band_decode (
    // capacity
    input  wire logic [15:0]       i_compensated_capacity,
    input  wire logic [7:0]        i_full_capacity_reference,
    // mode and flags
    input  wire lcd_pkg::lcd_mode_t i_mode,
    input  wire logic              i_first_low_voltage_flag,
    // pattern
    output logic      [4:0]        o_pattern,
    output logic                   o_blink_led_segment_one
);

    logic [lcd_pkg::NUM_BANDS-1:0] ge;
    logic [23:0]                   cap_scaled;

    assign cap_scaled = 24'(i_compensated_capacity) * lcd_pkg::PCT_FULL;

    // lower bound inclusive; zero reference leaves every band clear
    genvar g;
    generate
        for (g = 0; g < lcd_pkg::NUM_BANDS; g++) begin : g_band
            logic [23:0] ref_scaled;
            assign ref_scaled = 24'({i_full_capacity_reference, 8'h00})
                * 24'(lcd_pkg::BAND_PCT[g*7 +: 7]);
            assign ge[g] = (i_full_capacity_reference != 8'h00)
                && (cap_scaled >= ref_scaled);
        end
    endgenerate

    always_comb begin
        o_pattern    = lcd_pkg::SEG_NONE;
        o_blink_led_segment_one = 1'b0;
        case (i_mode)
            lcd_pkg::LCD_MODE_INC: begin
                if (i_first_low_voltage_flag) begin
                    o_pattern    = 5'h01;
                    o_blink_led_segment_one = 1'b1;
                end else if (ge[lcd_pkg::B90]) begin
                    o_pattern = 5'h08;
                end else if (ge[lcd_pkg::B50]) begin
                    o_pattern = 5'h04;
                end else if (ge[lcd_pkg::B20]) begin
                    o_pattern = 5'h02;
                end else begin
                    o_pattern = 5'h01;
                end
            end
            lcd_pkg::LCD_MODE_BIN: begin
                if (ge[lcd_pkg::B70]) begin
                    o_pattern = 5'h03;
                end else if (ge[lcd_pkg::B40]) begin
                    o_pattern = 5'h01;
                end else if (ge[lcd_pkg::B10]) begin
                    o_pattern = 5'h02;
                end else begin
                    o_pattern = lcd_pkg::SEG_NONE;
                end
            end
            default: begin
                // reserved strap code falls back to bar graph
                if (i_first_low_voltage_flag) begin
                    o_pattern    = 5'h01;
                    o_blink_led_segment_one = 1'b1;
                end else if (ge[lcd_pkg::B80]) begin
                    o_pattern = 5'h1F;
                end else if (ge[lcd_pkg::B60]) begin
                    o_pattern = 5'h0F;
                end else if (ge[lcd_pkg::B40]) begin
                    o_pattern = 5'h07;
                end else if (ge[lcd_pkg::B20]) begin
                    o_pattern = 5'h03;
                end else begin
                    o_pattern = 5'h01;
                end
            end
        endcase
    end

endmodule // lcd_band_decode

/* File: verification/lcd_chk_checker.sv */
`timescale 1ns/1ps

module lcd_chk #(
    parameter int unsigned BANK_ON_CYC = 30
) (
    // clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_clk_en,
    // register writes, gauge inputs, request pin and straps
    input wire logic       i_cmd_wr,
    input wire logic [6:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_data,
    input wire logic [7:0] i_programmed_full_count,
    input wire logic       i_first_low_voltage,
    input wire logic       i_final_low_voltage,
    input wire logic       i_display_request_n,
    input wire logic [1:0] i_display_mode_strap,
    input wire logic       i_full_init_strap,
    // outputs watched
    input wire logic [4:0] o_led_segment_oe,
    input wire logic       o_led_common_drive,
    input wire logic [7:0] o_full_capacity_reference,
    input wire logic [7:0] o_capacity_low_byte,
    input wire logic [7:0] o_relative_charge,
    input wire logic [7:0] o_primary_flags
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // length of the current odd bank window
    int unsigned run_q;
    int unsigned run_d;
    always_comb begin
        // a frozen clock holds the window, so the count must hold too
        if (!i_clk_en) begin
            run_d = run_q;
        end else begin
            run_d = ((o_led_segment_oe & 5'h15) != 5'h00) ? run_q + 1 : 0;
        end
    end
    always_ff @(posedge i_core_clk) begin
        run_q <= i_sys_rst ? 0 : run_d;
    end

    sequence s_reinit;
        i_clk_en && i_cmd_wr && i_cmd_addr == 7'h00 && i_cmd_data == 8'h78;
    endsequence

    property p_banks;
        (o_led_segment_oe & 5'h15) == 5'h00 ||
        (o_led_segment_oe & 5'h0A) == 5'h00;
    endproperty
    a_banks: assert property (p_banks)
        else $error("both banks lit together");
    property p_duty;
        run_q <= BANK_ON_CYC;
    endproperty
    a_duty: assert property (p_duty)
        else $error("bank window too long");
    property p_flags;
        $past(i_clk_en) && !$past(i_sys_rst) |-> o_primary_flags[1:0] ==
            {$past(i_first_low_voltage), $past(i_final_low_voltage)};
    endproperty
    a_flags: assert property (p_flags)
        else $error("low voltage flags do not track");
    property p_final;
        // flag register first, then the segment register: two live edges
        i_final_low_voltage && i_clk_en ##1 i_clk_en |=>
            o_led_segment_oe == 5'h00;
    endproperty
    a_final: assert property (p_final)
        else $error("segment lit at final low voltage");
    property p_inc;
        i_display_mode_strap == 2'h0 |->
            $onehot0(o_led_segment_oe) && !o_led_segment_oe[4];
    endproperty
    a_inc: assert property (p_inc)
        else $error("incremental mode lit wrong segments");
    property p_bin;
        i_display_mode_strap == 2'h1 |-> o_led_segment_oe[4:2] == 3'h0;
    endproperty
    a_bin: assert property (p_bin)
        else $error("binary mode used upper segments");
    property p_reinit;
        s_reinit ##1 i_clk_en |=> o_capacity_low_byte == 8'h00 &&
            o_relative_charge == (i_full_init_strap ? 8'h64 : 8'h00);
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("reinit values missing");
    property p_init;
        s_reinit ##1 i_clk_en |=> o_full_capacity_reference ==
            (i_full_init_strap ? i_programmed_full_count : 8'h00) &&
            o_primary_flags[7:2] == (i_full_init_strap ? 6'h24 : 6'h04);
    endproperty
    a_init: assert property (p_init)
        else $error("init reference or flags wrong");
    property p_req;
        i_display_request_n && i_clk_en |=> o_led_segment_oe == 5'h00 &&
            !o_led_common_drive;
    endproperty
    a_req: assert property (p_req)
        else $error("display on without request");
    property p_common;
        !o_led_common_drive |-> o_led_segment_oe == 5'h00;
    endproperty
    a_common: assert property (p_common)
        else $error("segment lit outside display period");
endmodule // lcd_chk

bind lcd_display_ctrl lcd_chk #(.BANK_ON_CYC(BANK_ON_CYC)) i_lcd_chk (.*);

/* File: verification/lcd_led_model.sv */
`timescale 1ns/1ps

module lcd_led_model (
    // block drive
    input  wire logic [4:0] i_seg_oe,
    input  wire logic       i_common,
    // bench side
    input  wire logic       i_press,
    // pins and light
    output logic      [4:0] o_seg_pin,
    output logic      [4:0] o_lit,
    output logic            o_display_request_n
);
    // leds hang from the common switch, so a released pin floats high
    assign o_seg_pin = ~i_seg_oe;
    assign o_lit = {5{i_common}} & ~o_seg_pin;
    // push button to ground, pulled up when open
    assign o_display_request_n = ~i_press;
endmodule // lcd_led_model

/* File: verification/led_capacity_display_tb_top.sv */
`timescale 1ns/1ps

module led_capacity_display_tb_top;
    logic        clk, rst, cmd_wr, cap_wr, f1, ff, press, fis, com, req_n;
    logic        ce;
    logic [6:0]  addr;
    logic [7:0]  data, programmed_full_count, rc, fcr, capacity_high_byte, capacity_low_byte, rco, flg;
    logic [15:0] cap;
    logic [1:0]  mode;
    logic [4:0]  oe, lit, pin, seen;
    int          failures, n_compared, on1, dur;
    int          bm [19] = '{0,0,0,0,0,0,1,1,1,1,1,1,2,2,2,2,2,2,2};
    int          bp [19] = '{90,89,50,49,20,19,70,69,40,39,10,9,
                             80,79,60,40,39,20,19};
    logic [4:0]  be [19] = '{5'h08,5'h04,5'h04,5'h02,5'h02,5'h01,5'h03,
        5'h01,5'h01,5'h02,5'h02,5'h00,5'h1F,5'h0F,5'h0F,5'h07,5'h03,
        5'h03,5'h01};

    lcd_display_ctrl #(.MUX_PERIOD_CYC(100), .BANK_ON_CYC(30),
        .BLINK_HALF_CYC(70), .DISPLAY_REQUEST_N_LONG_CYC(1000), .DISPLAY_REQUEST_N_SHORT_CYC(400)
    ) i_lcd_display_ctrl (
        .i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(ce),
        .i_cmd_wr(cmd_wr), .i_cmd_addr(addr), .i_cmd_data(data),
        .i_programmed_full_count(programmed_full_count), .i_capacity_wr(cap_wr),
        .i_capacity_value(cap), .i_relative_charge(rc),
        .i_first_low_voltage(f1), .i_final_low_voltage(ff),
        .i_display_request_n(req_n), .i_display_mode_strap(mode),
        .i_full_init_strap(fis), .o_led_segment_oe(oe),
        .o_led_common_drive(com), .o_full_capacity_reference(fcr),
        .o_capacity_high_byte(capacity_high_byte), .o_capacity_low_byte(capacity_low_byte),
        .o_relative_charge(rco), .o_primary_flags(flg));

    lcd_led_model i_lcd_led_model (.i_seg_oe(oe), .i_common(com),
        .i_press(press), .o_seg_pin(pin), .o_lit(lit),
        .o_display_request_n(req_n));

    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // straps move only under reset so the latched mode never goes stale
    task automatic do_reset(input logic [1:0] m, input logic f);
        mode = m;
        fis = f;
        rst = 1;
        tick(20);
        rst = 0;
        tick(2);
    endtask
    task automatic wr_cmd(input logic [6:0] a, input logic [7:0] d);
        cmd_wr = 1;
        addr = a;
        data = d;
        tick(1);
        cmd_wr = 0;
        tick(2);
    endtask
    task automatic load(input logic [15:0] v);
        cap_wr = 1;
        cap = v;
        tick(1);
        cap_wr = 0;
        tick(1);
    endtask
    // holds the request low n cycles, gathering what the leds showed
    task automatic show(input int n);
        seen = 5'h00;
        on1 = 0;
        dur = 0;
        press = 1;
        repeat (n) begin
            tick(1);
            seen |= lit;
            on1 += lit[0];
            dur += com;
        end
        press = 0;
        tick(2);
    endtask

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        failures++;
        $display("ERROR watchdog expected end seen hang");
        stop_test;
    end
    initial begin
        {rst, cmd_wr, cap_wr, f1, ff, press, addr, data, cap} = '0;
        ce = 1;
        rst = 1;
        programmed_full_count = 8'hC8;
        rc = 8'h33;
        fis = 1;
        mode = 2'h0;
        // full reference C8h: capacity 512 per percent
        for (int i = 0; i < 19; i++) begin
            if (i == 0 || bm[i] != bm[i-1]) begin
                do_reset(bm[i][1:0], 1'b1);
            end
            load(16'(512 * bp[i]));
            show(200);
            chk("band", {3'h0, be[i]}, {3'h0, seen});
        end
        show(600);
        chk("short", 8'h01, {7'h0, dur >= 398 && dur <= 402});
        do_reset(2'h0, 1'b1);
        chk("fcr", 8'hC8, fcr);
        chk("capacity_high_byte", 8'hC8, capacity_high_byte);
        chk("rc", 8'h64, rco);
        chk("flags", 8'h90, flg);
        load(16'hC800);
        show(1300);
        chk("full", 8'h08, {3'h0, seen});
        chk("long", 8'h01, {7'h0, dur >= 998 && dur <= 1002});
        f1 = 1;
        show(700);
        chk("blink", 8'h01, {3'h0, seen});
        chk("half", 8'h01, {7'h0, on1 >= 90 && on1 <= 120});
        f1 = 0;
        ff = 1;
        show(200);
        chk("final", 8'h00, {3'h0, seen});
        chk("pins", 8'h1F, {3'h0, pin});
        ff = 0;
        rc = 8'h5A;
        load(16'h1234);
        // a load with the enable low must leave the capacity untouched
        ce = 0;
        load(16'h4321);
        chk("freeze", 8'h34, capacity_low_byte);
        ce = 1;
        wr_cmd(7'h01, 8'h78);
        chk("badaddr", 8'h34, capacity_low_byte);
        wr_cmd(7'h00, 8'h55);
        chk("baddata", 8'h5A, rco);
        wr_cmd(7'h00, 8'h78);
        chk("reinit", 8'h00, capacity_low_byte);
        chk("rcinit", 8'h64, rco);
        // a changed full count must not reach the registers on empty init
        programmed_full_count = 8'h3C;
        do_reset(2'h0, 1'b0);
        chk("fcr0", 8'h00, fcr);
        chk("cach0", 8'h00, capacity_high_byte);
        chk("flags0", 8'h10, flg);
        load(16'h0100);
        show(200);
        chk("zeroref", 8'h01, {3'h0, seen});
        stop_test;
    end
endmodule // led_capacity_display_tb_top
